// ### rtl/xcvr_verifier_pkg.sv
// Package of register map, field positions and timing for the transceiver verifier
package xcvr_verifier_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00; // Reset and power control
  localparam logic [7:0] STAT_OFS = 8'h04; // Verifier status, read only
  localparam logic [7:0] ISR_OFS = 8'h08; // Sticky event flags, write one to clear
  localparam logic [7:0] IMR_OFS = 8'h0C; // Event mask, one enables
  // ---------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------
  localparam int C_BLK_PD = 0; // Block power down
  localparam int C_RX_ARST = 1; // Receiver analog reset
  localparam int C_RX_DRST = 2; // Receiver coding sublayer reset
  localparam int C_TX_DRST = 3; // Transmitter coding sublayer reset
  localparam int C_CAL_PD = 4; // Calibration block power down
  localparam int C_MODE = 5; // 0 incremental, 1 pseudo-random
  localparam int C_EN = 6; // Verifier enable
  localparam int CTRL_W = 7; // Control width
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h0F; // Resets and block down at start
  // ---------------------------------------------------------------
  // Status and event bits
  // ---------------------------------------------------------------
  localparam int S_ERR = 0; // Error flag / error event
  localparam int S_DONE = 1; // Done flag / done event
  localparam int EV_W = 2; // Event count
  // ---------------------------------------------------------------
  // Timing and pattern constants
  // ---------------------------------------------------------------
  localparam int RX_CLK_PERIOD_NS = 4; // Recovered receive clock period
  localparam int ERR_HOLD_CLK = 3; // Least error hold in receive clocks
  localparam int ERR_HOLD_NS = ERR_HOLD_CLK * RX_CLK_PERIOD_NS; // Hold time
  localparam logic [1:0] HOLD_CYC = 2'((ERR_HOLD_NS + 3) / 4); // Rounded up at 4 ns
  localparam int PRBS_W = 7; // Pseudo-random register width
  localparam int PRBS_LEN = 127; // Words in one pseudo-random cycle
  // Verifier states
  typedef enum logic [0:0] {
    ST_SYNC = 1'b0, // Wait for first word to seed
    ST_RUN = 1'b1 // Compare each word
  } vstate_e;
endpackage

// ### rtl/xcvr_verifier.sv
// Reset, power and pattern verifier block of one transceiver channel
`timescale 1ns/1ps
// Overview of operation
// RULE1: Block power down gates all channel circuitry
// RULE2: Receiver analog reset follows its control
// RULE3: Receiver coding reset follows its control
// RULE4: Transmitter coding reset follows its control
// RULE5: Calibration clock forwarded, separate power down
// RULE6: Incremental mode error flag stays high until the verifier is cleared
// RULE7: Pseudo-random error holds three clocks, clears later
// RULE8: Incremental done after full cycle or error
// RULE9: Pseudo-random done after one full cycle
// RULE10: Receiver coding reset clears both flags
module xcvr_verifier
  import xcvr_verifier_pkg::*;
#(
  parameter int DATA_W = 8 // Receive word width
) (
  input wire logic pclk, // APB clock, 250 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic [7:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic blk_pd_pin, // Asynchronous block power down request
  input wire logic rx_valid, // Receive word valid
  input wire logic [DATA_W-1:0] rx_data, // Receive parallel word
  input wire logic cal_clk, // Dedicated calibration clock
  output logic blk_pd, // Power down to channel circuitry
  output logic rx_pma_rst, // Receiver analog section reset
  output logic rx_pcs_rst, // Receiver coding sublayer reset
  output logic tx_pcs_rst, // Transmitter coding sublayer reset
  output logic cal_pd, // Calibration block power down
  output logic cal_clk_out, // Clock to calibration block
  output logic verify_err, // Verifier error flag
  output logic verify_done, // Verifier done flag
  output logic irq // Level interrupt
);
  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (DATA_W < PRBS_W || DATA_W > 16) begin : g_bad_width
    $error("DATA_W must lie between 7 and 16");
  end

  localparam logic [DATA_W-1:0] INC_LAST = '1; // Last count of an incremental cycle
  localparam logic [DATA_W-1:0] PRBS_LAST = DATA_W'(PRBS_LEN - 1); // Last pseudo-random count

  // ---------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl; // Control register
    logic [EV_W-1:0] isr; // Sticky events
    logic [EV_W-1:0] imr; // Event mask
    logic [31:0] rdata; // Registered read data
    vstate_e vst; // Verifier state
    logic [DATA_W-1:0] expect_w; // Next expected word
    logic [DATA_W-1:0] cnt; // Words in current cycle
    logic err; // Error flag
    logic done; // Done flag
    logic [1:0] hold; // Error hold countdown
    logic cyc_bad; // Error seen in current cycle
  } state_s;

  state_s st_ff; // Registered state
  state_s nxt_st; // Next state

  logic wr_acc; // Write access phase
  logic rd_setup; // Read setup phase
  logic addr_ok; // Address maps to a register
  logic clr_all; // Verifier held clear
  logic prbs; // Pseudo-random mode
  logic mism; // Word mismatch this cycle
  logic last; // Last word of a cycle
  logic [DATA_W-1:0] adv_w; // Advanced expected word
  logic [DATA_W-1:0] seed_w; // Expected after a seed word
  logic [EV_W-1:0] ev; // Events raised this cycle

  // Next pattern word from a given word
  function automatic logic [DATA_W-1:0] advance(input logic [DATA_W-1:0] w, input logic p);
    logic [DATA_W-1:0] r;
    r = '0;
    if (p) begin
      r[PRBS_W-1:0] = {w[PRBS_W-2:0], w[PRBS_W-1] ^ w[PRBS_W-2]};
    end else begin
      r = w + 1'b1;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Pin-level control
  // ---------------------------------------------------------------
  // Async pin bypasses flops so power down acts without a clock
  assign blk_pd = st_ff.ctrl[C_BLK_PD] | blk_pd_pin; // [RULE1]
  assign rx_pma_rst = st_ff.ctrl[C_RX_ARST]; // [RULE2]
  assign rx_pcs_rst = st_ff.ctrl[C_RX_DRST]; // [RULE3]
  assign tx_pcs_rst = st_ff.ctrl[C_TX_DRST]; // [RULE4]
  assign cal_pd = st_ff.ctrl[C_CAL_PD]; // [RULE5]
  assign cal_clk_out = cal_clk; // [RULE5]
  assign verify_err = st_ff.err;
  assign verify_done = st_ff.done;
  assign irq = |(st_ff.isr & st_ff.imr);
  assign prdata = st_ff.rdata;
  assign pready = 1'b1;

  // ---------------------------------------------------------------
  // Decode and compare helpers
  // ---------------------------------------------------------------
  always_comb begin
    addr_ok = 1'b0;
    if (paddr == CTRL_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == STAT_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == ISR_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == IMR_OFS) begin
      addr_ok = 1'b1;
    end
  end

  assign pslverr = psel & penable & ~addr_ok;
  assign wr_acc = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  // Power down or coding reset wipes the verifier
  assign clr_all = blk_pd | st_ff.ctrl[C_RX_DRST] | ~st_ff.ctrl[C_EN]; // [RULE10]
  assign prbs = st_ff.ctrl[C_MODE];
  assign mism = (st_ff.vst == ST_RUN) && rx_valid && (rx_data != st_ff.expect_w);
  assign last = (st_ff.vst == ST_RUN) && rx_valid && (st_ff.cnt == (prbs ? PRBS_LAST : INC_LAST));
  assign adv_w = advance(st_ff.expect_w, prbs);
  assign seed_w = advance(prbs ? {{(DATA_W-PRBS_W){1'b0}}, rx_data[PRBS_W-1:0]} : rx_data, prbs);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    ev = '0;
    // Register writes
    if (wr_acc) begin
      if (paddr == CTRL_OFS) begin
        nxt_st.ctrl = pwdata[CTRL_W-1:0];
      end else if (paddr == IMR_OFS) begin
        nxt_st.imr = pwdata[EV_W-1:0];
      end
    end
    // Read data captured in setup so it comes from a flop
    if (rd_setup) begin
      nxt_st.rdata = '0;
      if (paddr == CTRL_OFS) begin
        nxt_st.rdata[CTRL_W-1:0] = st_ff.ctrl;
      end else if (paddr == STAT_OFS) begin
        nxt_st.rdata[EV_W-1:0] = {st_ff.done, st_ff.err};
      end else if (paddr == ISR_OFS) begin
        nxt_st.rdata[EV_W-1:0] = st_ff.isr;
      end else if (paddr == IMR_OFS) begin
        nxt_st.rdata[EV_W-1:0] = st_ff.imr;
      end
    end
    // Hold countdown runs every cycle
    if (st_ff.hold != 2'h0) begin
      nxt_st.hold = st_ff.hold - 2'h1;
    end
    if (clr_all) begin
      // Fresh check after reset release
      nxt_st.vst = ST_SYNC; // [RULE10]
      nxt_st.err = 1'b0; // [RULE10]
      nxt_st.done = 1'b0; // [RULE10]
      nxt_st.hold = 2'h0;
      nxt_st.cyc_bad = 1'b0;
      nxt_st.cnt = '0;
    end else if (st_ff.vst == ST_SYNC) begin
      // First word seeds the expected sequence
      if (rx_valid) begin
        nxt_st.vst = ST_RUN;
        nxt_st.expect_w = seed_w;
        nxt_st.cnt = DATA_W'(1);
      end
    end else if (rx_valid) begin
      nxt_st.expect_w = adv_w;
      nxt_st.cnt = last ? '0 : st_ff.cnt + 1'b1;
      if (!prbs) begin
        // Incremental: error sticks, done on cycle end or error
        if (mism) begin
          nxt_st.err = 1'b1; // [RULE6]
        end
        if (mism || last) begin
          nxt_st.done = 1'b1; // [RULE8]
        end
      end else begin
        if (mism) begin
          nxt_st.err = 1'b1; // [RULE7]
          nxt_st.hold = HOLD_CYC; // [RULE7]
        end
        if (last) begin
          nxt_st.done = 1'b1; // [RULE9]
          // A clean cycle after the hold clears the flag
          if (!st_ff.cyc_bad && !mism && st_ff.hold == 2'h0) begin
            nxt_st.err = 1'b0; // [RULE7]
          end
        end
        nxt_st.cyc_bad = mism | (st_ff.cyc_bad & ~last);
      end
    end
    // Events on rising flags; set beats a write-one clear
    ev[S_ERR] = nxt_st.err & ~st_ff.err;
    ev[S_DONE] = nxt_st.done & ~st_ff.done;
    if (wr_acc && paddr == ISR_OFS) begin
      nxt_st.isr = st_ff.isr & ~pwdata[EV_W-1:0];
    end
    nxt_st.isr = nxt_st.isr | ev;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Mismatch seen while the verifier runs in incremental mode
  sequence s_inc_err;
    !prbs && !clr_all && mism;
  endsequence

  // Mismatch seen while the verifier runs in pseudo-random mode
  sequence s_prbs_err;
    prbs && !clr_all && mism;
  endsequence

  // Last word of a pseudo-random cycle that closes a clean cycle
  sequence s_prbs_clean;
    prbs && !clr_all && last && !mism && !st_ff.cyc_bad && st_ff.hold == 2'h0;
  endsequence

  // Access phase of a write to the control register
  sequence s_wr_ctrl;
    wr_acc && paddr == CTRL_OFS;
  endsequence

  // Pin-level controls follow the control register and the pin
  a_pd_follow: assert property (st_ff.ctrl[C_BLK_PD] |-> blk_pd) // [RULE1]
    else $error("block power down not driven");
  a_pd_pin: assert property (blk_pd_pin |-> blk_pd) // [RULE1]
    else $error("power down pin not passed on");
  a_rxa_write: assert property (s_wr_ctrl |=> rx_pma_rst == $past(pwdata[C_RX_ARST])) // [RULE2]
    else $error("receiver analog reset not updated");
  a_rxd_write: assert property (wr_acc && paddr == CTRL_OFS |=> rx_pcs_rst == $past(pwdata[C_RX_DRST])) // [RULE3]
    else $error("receiver coding reset not updated");
  a_txd_write: assert property (wr_acc && paddr == CTRL_OFS |=> tx_pcs_rst == $past(pwdata[C_TX_DRST])) // [RULE4]
    else $error("transmitter coding reset not updated");
  a_cal_write: assert property (s_wr_ctrl |=> cal_pd == $past(pwdata[C_CAL_PD])) // [RULE5]
    else $error("calibration power down not updated");

  // Verifier error flag in both modes
  a_inc_sticky: assert property (s_inc_err |=> verify_err && verify_done ##1 (verify_err || clr_all)) // [RULE6]
    else $error("incremental error flag not sticky");
  a_inc_keep: assert property (!prbs && verify_err && !clr_all |=> verify_err) // [RULE6]
    else $error("incremental error flag dropped");
  a_prbs_hold: assert property (s_prbs_err ##1 (!clr_all)[*2] |=> // [RULE7]
    verify_err && $past(verify_err) && $past(verify_err, 2))
    else $error("pseudo-random error held under three cycles");
  a_prbs_keep: assert property (prbs && verify_err && !clr_all && !last |=> verify_err) // [RULE7]
    else $error("pseudo-random error dropped inside a cycle");
  a_prbs_clear: assert property (s_prbs_clean |=> !verify_err) // [RULE7]
    else $error("pseudo-random error kept after clean cycle");

  // Verifier done flag: raised only for a cause, then kept
  a_done_end: assert property (!clr_all && last |=> verify_done) // [RULE8]
    else $error("done not raised at cycle end");
  a_done_cause: assert property ($rose(verify_done) |-> $past(!clr_all && (last || (mism && !prbs)))) // [RULE8]
    else $error("done rose without cause");
  a_done_keep: assert property (verify_done && !clr_all |=> verify_done) // [RULE9]
    else $error("done dropped without reset");

  // Coding reset, power down or disable wipes both flags
  a_clr_flags: assert property (clr_all |=> !verify_err && !verify_done) // [RULE10]
    else $error("flags not cleared by reset");
endmodule

// ### testbench/fabric_ctrl_model.sv
// Fabric-side model: receive pattern source and calibration clock
`timescale 1ns/1ps
module fabric_ctrl_model (
  input wire logic pclk, // Receive parallel clock
  input wire logic run, // Send one word per cycle while high
  input wire logic prbs, // 0 incremental, 1 pseudo-random
  input wire logic inject, // Corrupt the word sent this cycle
  input wire logic reseed, // Restart the pattern at the seed
  output logic rx_valid, // Word valid
  output logic [7:0] rx_data, // Word
  output logic cal_clk // Dedicated calibration clock
);
  logic [7:0] w_ff; // Next good word of the pattern
  // ---------------------------------------------------------------
  // Calibration clock, free running, unrelated to pclk
  // ---------------------------------------------------------------
  initial begin
    cal_clk = 1'b0;
    forever #5 cal_clk = ~cal_clk;
  end
  // ---------------------------------------------------------------
  // Pattern source; idle data toggles so stale words never match
  // ---------------------------------------------------------------
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h05;
    w_ff = 8'h05;
    forever begin
      @(posedge pclk);
      if (run) begin
        rx_valid <= 1'b1;
        rx_data <= inject ? ~w_ff : w_ff;
        w_ff <= prbs ? {1'b0, w_ff[5:0], w_ff[6] ^ w_ff[5]} : w_ff + 8'h01;
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        if (reseed) begin
          w_ff <= 8'h05; // Seed restarts with the verifier
        end
      end
    end
  end
endmodule

// ### testbench/transceiver_reset_and_pattern_verifier_tb_top.sv
// Self-checking bench of the transceiver verifier block
`timescale 1ns/1ps
module transceiver_reset_and_pattern_verifier_tb_top;
  import xcvr_verifier_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, blk_pd_pin, rx_valid, cal_clk, cal_clk_out;
  logic [7:0] paddr, rx_data;
  logic [31:0] pwdata, prdata;
  logic blk_pd, rx_pma_rst, rx_pcs_rst, tx_pcs_rst, cal_pd, verify_err, verify_done, irq;
  logic run, prbs, inject; // Partner controls
  logic [32:0] exp_q[$]; // Expected {pslverr, prdata} of each read
  int error_cnt = 0; // Mismatches
  int n_compared = 0; // Comparisons
  // ---------------------------------------------------------------
  // Clock, device and partner
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  xcvr_verifier u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .blk_pd_pin(blk_pd_pin), .rx_valid(rx_valid), .rx_data(rx_data), .cal_clk(cal_clk), .blk_pd(blk_pd),
    .rx_pma_rst(rx_pma_rst), .rx_pcs_rst(rx_pcs_rst), .tx_pcs_rst(tx_pcs_rst), .cal_pd(cal_pd),
    .cal_clk_out(cal_clk_out), .verify_err(verify_err), .verify_done(verify_done), .irq(irq));
  fabric_ctrl_model u_partner (.pclk(pclk), .run(run), .prbs(prbs), .inject(inject), .reseed(rx_pcs_rst),
    .rx_valid(rx_valid), .rx_data(rx_data), .cal_clk(cal_clk));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One APB transfer; a read notes its expected answer first
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] exp);
    if (!w) begin
      exp_q.push_back(exp);
    end
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Send n words, corrupting word number bad (negative for none)
  task automatic stream(input int n, input int bad);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      run <= 1'b1;
      inject <= (i == bad);
    end
    @(posedge pclk);
    run <= 1'b0;
    inject <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // Read monitor: compares each completed read with the oldest note
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // Watchdog
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [4:0] v;
    logic p;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    blk_pd_pin = 1'b0;
    run = 1'b0;
    prbs = 1'b0;
    inject = 1'b0;
    void'($urandom(32'he5ec));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check({blk_pd, rx_pma_rst, rx_pcs_rst, tx_pcs_rst, cal_pd}, 33'h1E);
    for (int i = 0; i < 4; i++) apb(8'(i * 4), 1'b0, 32'h0, (i == 0) ? 33'h0F : 33'h0);
    apb(8'h10, 1'b0, 32'h0, {1'b1, 32'h0});
    // Random control patterns, with the asynchronous power-down pin
    for (int i = 0; i < 6; i++) begin
      v = 5'($urandom);
      p = 1'($urandom);
      blk_pd_pin <= p;
      apb(CTRL_OFS, 1'b1, {27'h0, v}, 33'h0);
      apb(CTRL_OFS, 1'b0, 32'h0, {28'h0, v});
      #1;
      check({blk_pd, rx_pma_rst, rx_pcs_rst, tx_pcs_rst, cal_pd}, {v[0] | p, v[1], v[2], v[3], v[4]});
      check(cal_clk_out, cal_clk);
    end
    blk_pd_pin <= 1'b0;
    apb(IMR_OFS, 1'b1, 32'h3, 33'h0);
    // Incremental pattern: done exactly after the full cycle, then a permanent error
    apb(CTRL_OFS, 1'b1, 32'h04, 33'h0);
    apb(CTRL_OFS, 1'b1, 32'h40, 33'h0);
    stream(255, -1);
    check({verify_err, verify_done}, 33'h0);
    stream(1, -1);
    check({verify_err, verify_done}, 33'h1);
    apb(CTRL_OFS, 1'b1, 32'h44, 33'h0);
    @(posedge pclk);
    #1;
    check({verify_err, verify_done}, 33'h0);
    apb(CTRL_OFS, 1'b1, 32'h40, 33'h0);
    stream(10, 3);
    check({verify_err, verify_done}, 33'h3);
    stream(300, -1);
    check({verify_err, verify_done, irq}, 33'h7);
    // Interrupt: read, clear one bit, mask, clear the other
    apb(ISR_OFS, 1'b0, 32'h0, 33'h3);
    apb(ISR_OFS, 1'b1, 32'h1, 33'h0);
    apb(ISR_OFS, 1'b0, 32'h0, 33'h2);
    apb(IMR_OFS, 1'b1, 32'h0, 33'h0);
    #1;
    check(irq, 33'h0);
    apb(ISR_OFS, 1'b1, 32'h2, 33'h0);
    apb(ISR_OFS, 1'b0, 32'h0, 33'h0);
    // Pseudo-random: done after one cycle, error held, cleared by clean cycles
    prbs <= 1'b1;
    apb(CTRL_OFS, 1'b1, 32'h64, 33'h0);
    apb(CTRL_OFS, 1'b1, 32'h60, 33'h0);
    stream(PRBS_LEN, -1);
    check({verify_err, verify_done}, 33'h1);
    stream(ERR_HOLD_CLK + 2, 0);
    check(verify_err, 33'h1);
    stream(3 * PRBS_LEN, -1);
    check({verify_err, verify_done}, 33'h1);
    apb(STAT_OFS, 1'b0, 32'h0, 33'h2);
    close_out();
  end
endmodule
